// ---- tb/rmac_config_regs_test.sv ----
// Self-checking testbench for the radio modem configuration bank
`timescale 1ns/1ps
`default_nettype none
module rmac_config_regs_test;
    import rmac_pkg::*;
    // Clock, reset and stimulus
    logic        clk;
    logic        rst;
    logic        regWr;
    logic        regRd;
    logic [9:0]  regAddr;
    logic [7:0]  regWrData;
    logic [2:0]  ev;
    logic [3:0]  preambleMatch;
    // Observed outputs
    logic [7:0]  regRdData;
    logic        regRdValid;
    logic [9:0]  ifBandwidthKhz;
    logic [9:0]  ifFreqKhz;
    logic [2:0]  txModulation;
    logic        txModReserved;
    logic [2:0]  rxDemodulator;
    logic        rxDemodReserved;
    logic        freqTrackEnable;
    logic        freqTrackFrozen;
    logic        freqTrackPolarity;
    logic [1:0]  freqTrackAlgorithm;
    logic [15:0] freqTrackPropGain;
    logic [15:0] freqTrackIntGain;
    logic [15:0] ookThreshPropGain;
    logic [15:0] ookThreshIntGain;
    // Bookkeeping
    int          nFail;
    int          testsRun;
    int          cycles;

    rmac_config_regs rmac_config_regs_inst (
        .clk(clk), .rst(rst), .regWr(regWr), .regRd(regRd),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .preambleDet(ev[0]),
        .syncWordDet(ev[1]), .rxFrameEnd(ev[2]),
        .preambleMatch(preambleMatch), .ifBandwidthKhz(ifBandwidthKhz),
        .ifFreqKhz(ifFreqKhz), .txModulation(txModulation),
        .txModReserved(txModReserved), .rxDemodulator(rxDemodulator),
        .rxDemodReserved(rxDemodReserved),
        .freqTrackEnable(freqTrackEnable),
        .freqTrackFrozen(freqTrackFrozen),
        .freqTrackPolarity(freqTrackPolarity),
        .freqTrackAlgorithm(freqTrackAlgorithm),
        .freqTrackPropGain(freqTrackPropGain),
        .freqTrackIntGain(freqTrackIntGain),
        .ookThreshPropGain(ookThreshPropGain),
        .ookThreshIntGain(ookThreshIntGain)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished, failures so far %0d", name, nFail);
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Register write, then wait until decoded outputs settle
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Register read, waits on the valid pulse under a bound
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        for (int i = 0; i < 5 && !seen; i++) begin
            @(posedge clk);
            #1;
            if (regRdValid === 1'b1) begin
                seen = 1'b1;
                chk({8'h00, regRdData}, {8'h00, exp});
            end
        end
        chk({15'h0, seen}, 16'h0001);
    endtask

    // Receiver status pulse, then wait for the freeze to settle
    task automatic pulse(input logic [2:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 3'b000;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic test_store();
        wr(10'h115, 8'hA5);
        wr(10'h116, 8'hE7);
        wr(10'h117, 8'h3C);
        wr(10'h118, 8'hFF);
        rd(10'h115, 8'hA5);
        rd(10'h116, 8'hE7);
        rd(10'h117, 8'h3C);
        rd(10'h118, 8'h00);
        rd(10'h114, 8'h00);
        chk({15'h0, freqTrackPolarity}, 16'h0000);
        chk({14'h0, freqTrackAlgorithm}, 16'h0001);
        done("store");
    endtask

    // Write then read of the same register in the next cycle
    task automatic test_b2b();
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= 10'h115;
        regWrData <= 8'h5A;
        @(posedge clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        #1;
        chk({15'h0, regRdValid}, 16'h0001);
        chk({8'h00, regRdData}, 16'h005A);
        @(posedge clk);
        #1;
        chk({15'h0, regRdValid}, 16'h0000);
        done("b2b");
    endtask

    // Reset in mid-run returns registers 0x115 and 0x117 and the bandwidth, IF, enable and gain outputs to their start
    task automatic test_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({15'h0, freqTrackEnable}, 16'h0000);
        chk({6'h0, ifBandwidthKhz}, 16'h0064);
        chk(freqTrackPropGain, 16'h0000);
        @(posedge clk);
        #1;
        chk({15'h0, freqTrackEnable}, 16'h0001);
        chk(freqTrackPropGain, 16'h0001);
        chk(freqTrackIntGain, 16'h0001);
        chk({6'h0, ifFreqKhz}, 16'h00C8);
        rd(10'h115, 8'h00);
        rd(10'h117, 8'h00);
        done("reset");
    endtask

    task automatic test_fields();
        logic [9:0] bw [4] = '{10'd100, 10'd150, 10'd200, 10'd300};
        for (int c = 0; c < 4; c++) begin
            wr(10'h115, {c[1:0], 6'h00});
            chk({6'h0, ifBandwidthKhz}, {6'h0, bw[c]});
            chk({6'h0, ifFreqKhz}, (c == 3) ? 16'd300 : 16'd200);
        end
        for (int c = 0; c < 8; c++) begin
            wr(10'h115, {2'b00, c[2:0], c[2:0]});
            chk({13'h0, txModulation}, c[15:0]);
            chk({15'h0, txModReserved}, {15'h0, c > 3});
            chk({13'h0, rxDemodulator}, c[15:0]);
            chk({15'h0, rxDemodReserved}, {15'h0, c != 0 && c != 2});
        end
        done("fields");
    endtask

    task automatic test_track();
        wr(10'h115, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wr(10'h116, {6'h00, m[1:0]});
            chk({15'h0, freqTrackEnable}, {15'h0, m != 1});
            chk({15'h0, freqTrackFrozen}, {15'h0, m == 2});
        end
        preambleMatch <= 4'h8;
        pulse(3'b010);
        chk({15'h0, freqTrackFrozen}, 16'h0000);
        pulse(3'b001);
        chk({15'h0, freqTrackFrozen}, 16'h0001);
        pulse(3'b100);
        chk({15'h0, freqTrackFrozen}, 16'h0000);
        pulse(3'b101);
        chk({15'h0, freqTrackFrozen}, 16'h0000);
        preambleMatch <= 4'h0;
        pulse(3'b001);
        chk({15'h0, freqTrackFrozen}, 16'h0000);
        pulse(3'b010);
        chk({15'h0, freqTrackFrozen}, 16'h0001);
        pulse(3'b100);
        wr(10'h116, 8'h00);
        pulse(3'b001);
        chk({15'h0, freqTrackFrozen}, 16'h0000);
        done("track");
    endtask

    task automatic test_gain();
        logic [15:0] pe;
        logic [15:0] ie;
        for (int o = 0; o < 2; o++) begin
            wr(10'h115, (o == 1) ? 8'h02 : 8'h00);
            for (int k = 0; k < 16; k++) begin
                wr(10'h117, {k[3:0], 4'hF - k[3:0]});
                pe = 16'h0001 << k;
                ie = 16'h0001 << (15 - k);
                chk(freqTrackPropGain, (o == 1) ? 16'h0000 : pe);
                chk(freqTrackIntGain, (o == 1) ? 16'h0000 : ie);
                chk(ookThreshPropGain, (o == 1) ? pe : 16'h0000);
                chk(ookThreshIntGain, (o == 1) ? ie : 16'h0000);
            end
            chk({15'h0, freqTrackEnable}, {15'h0, o == 0});
        end
        wr(10'h117, 8'h36);
        chk(ookThreshPropGain, 16'h0008);
        chk(ookThreshIntGain, 16'h0040);
        wr(10'h115, 8'h00);
        wr(10'h117, 8'h37);
        chk(freqTrackPropGain, 16'h0008);
        chk(freqTrackIntGain, 16'h0080);
        done("gain");
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            nFail++;
            results();
        end
    end

    initial begin
        nFail = 0;
        testsRun = 0;
        cycles = 0;
        rst = 1'b1;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 10'h000;
        regWrData = 8'h00;
        ev = 3'b000;
        preambleMatch = 4'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        test_store();
        test_b2b();
        test_fields();
        test_track();
        test_gain();
        test_reset();
        results();
    end
endmodule
`default_nettype wire

// ---- verilog/rmac_config_regs.sv ----
// Radio modem bandwidth, modulation and frequency-tracking configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "rmac_consts.svh"
// Overview of operation
// - The IF bandwidth code 0..3 selects 100, 150, 200 or 300 kHz.
// - Bandwidth code 3 moves the receive IF from 200 kHz to 300 kHz.
// - The modulation field picks FSK, GFSK, OOK or carrier; 4-7 reserved.
// - The demodulation field picks FSK family (0) or OOK (2); others reserved.
// - The tracking mode field selects free, disabled, hold or lock.
// - Lock mode freezes at preamble, or at sync word if preamble match is 0.
// - Proportional gain is two to the power of the 4-bit code.
// - With OOK demodulation the proportional gain drives the threshold loop.
// - Integral gain is two to the power of its code, in either loop.
module rmac_config_regs
    import rmac_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register access from the serial control port
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWrData,
    output var  logic [7:0]        regRdData,
    output var  logic              regRdValid,
    // Receiver status
    input  wire logic              preambleDet,
    input  wire logic              syncWordDet,
    input  wire logic              rxFrameEnd,
    input  wire logic [3:0]        preambleMatch,
    // Decoded configuration
    output var  logic [9:0]        ifBandwidthKhz,
    output var  logic [9:0]        ifFreqKhz,
    output var  logic [2:0]        txModulation,
    output var  logic              txModReserved,
    output var  logic [2:0]        rxDemodulator,
    output var  logic              rxDemodReserved,
    output var  logic              freqTrackEnable,
    output var  logic              freqTrackFrozen,
    output var  logic              freqTrackPolarity,
    output var  logic [1:0]        freqTrackAlgorithm,
    output var  logic [15:0]       freqTrackPropGain,
    output var  logic [15:0]       freqTrackIntGain,
    output var  logic [15:0]       ookThreshPropGain,
    output var  logic [15:0]       ookThreshIntGain
);
    logic [23:0] allData;
    logic [7:0]  rdData;
    logic [1:0]  wrIdx;
    logic        hitMod;
    logic        hitTrk;
    logic        hitGain;
    logic        hitAny;
    logic [7:0]  modBwCfg;
    logic [7:0]  trkModeCfg;
    logic [7:0]  trkGainCfg;
    logic [1:0]  if_filter_bw_sel;
    logic [2:0]  tx_modulation_sel;
    logic [2:0]  rx_demodulator_sel;
    logic [1:0]  freq_track_mode;
    logic [3:0]  freq_track_prop_gain;
    logic [3:0]  freq_track_int_gain;
    logic        demodOok;
    logic        trackOn;
    logic        lockEvent;
    logic        frozen_reg;
    logic        frozen_next;
    logic        lockPrev_reg;
    logic        modeLock;
    logic        rdPend_reg;
    logic        rdHit_reg;
    logic [9:0]  bwKhz;
    logic [15:0] propPow;
    logic [15:0] intPow;

    assign hitMod  = (regAddr == `RMAC_ADDR_MODBW);
    assign hitTrk  = (regAddr == `RMAC_ADDR_TRKMODE);
    assign hitGain = (regAddr == `RMAC_ADDR_TRKGAIN);
    assign hitAny  = hitMod | hitTrk | hitGain;
    assign wrIdx   = hitMod ? 2'd0 : (hitTrk ? 2'd1 : 2'd2);

    rmac_reg_store #(
        .WIDTH (8),
        .DEPTH (3)
    ) rmac_reg_store_inst (
        .clk     (clk),
        .rst     (rst),
        .wrEn    (regWr & hitAny),
        .wrIdx   (wrIdx),
        .wrData  (regWrData),
        .rdIdx   (wrIdx),
        .rdData  (rdData),
        .allData (allData)
    );

    assign modBwCfg   = allData[7:0];
    assign trkModeCfg = allData[15:8];
    assign trkGainCfg = allData[23:16];

    assign if_filter_bw_sel     = modBwCfg[`RMAC_BW_HI:`RMAC_BW_LO];
    assign tx_modulation_sel    = modBwCfg[`RMAC_MOD_HI:`RMAC_MOD_LO];
    assign rx_demodulator_sel   = modBwCfg[`RMAC_DEMOD_HI:`RMAC_DEMOD_LO];
    assign freq_track_mode      = trkModeCfg[`RMAC_TRK_HI:`RMAC_TRK_LO];
    assign freq_track_prop_gain = trkGainCfg[`RMAC_KP_HI:`RMAC_KP_LO];
    assign freq_track_int_gain  = trkGainCfg[`RMAC_KI_HI:`RMAC_KI_LO];

    // Bandwidth lookup
    assign bwKhz = (if_filter_bw_sel == RMAC_BW_100) ? `RMAC_BW_KHZ_0 :
                   (if_filter_bw_sel == RMAC_BW_150) ? `RMAC_BW_KHZ_1 :
                   (if_filter_bw_sel == RMAC_BW_200) ? `RMAC_BW_KHZ_2 :
                   `RMAC_BW_KHZ_3;

    // Gains as powers of two
    assign propPow = `RMAC_ONE_HOT_ONE << freq_track_prop_gain;
    assign intPow  = `RMAC_ONE_HOT_ONE << freq_track_int_gain;
    assign demodOok = (rx_demodulator_sel == RMAC_DEM_OOK);

    // Tracking mode and lock freeze
    assign trackOn = (freq_track_mode != RMAC_TRK_OFF);
    assign lockEvent = (preambleMatch == `RMAC_PREAMBLE_OFF) ? syncWordDet
                                                              : preambleDet;
    assign modeLock = (freq_track_mode == RMAC_TRK_LOCK);
    always_comb begin
        frozen_next = frozen_reg;
        case (freq_track_mode)
            RMAC_TRK_LOCK: begin
                // Entering lock starts unfrozen
                frozen_next = frozen_reg & lockPrev_reg;
                if (rxFrameEnd) begin
                    frozen_next = 1'b0;
                end else if (lockEvent) begin
                    frozen_next = 1'b1;
                end
            end
            RMAC_TRK_HOLD: frozen_next = 1'b1;
            default:       frozen_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frozen_reg   <= 1'b0;
            lockPrev_reg <= 1'b0;
        end else begin
            frozen_reg   <= frozen_next;
            lockPrev_reg <= modeLock;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdPend_reg <= 1'b0;
            rdHit_reg  <= 1'b0;
        end else begin
            rdPend_reg <= regRd;
            rdHit_reg  <= regRd & hitAny;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData          <= `RMAC_RESET_VAL;
            regRdValid         <= 1'b0;
            ifBandwidthKhz     <= `RMAC_BW_KHZ_0;
            ifFreqKhz          <= `RMAC_IF_KHZ_NORMAL;
            txModulation       <= 3'h0;
            txModReserved      <= 1'b0;
            rxDemodulator      <= 3'h0;
            rxDemodReserved    <= 1'b0;
            freqTrackEnable    <= 1'b0;
            freqTrackFrozen    <= 1'b0;
            freqTrackPolarity  <= 1'b0;
            freqTrackAlgorithm <= 2'h0;
            freqTrackPropGain  <= 16'h0000;
            freqTrackIntGain   <= 16'h0000;
            ookThreshPropGain  <= 16'h0000;
            ookThreshIntGain   <= 16'h0000;
        end else begin
            regRdData  <= rdHit_reg ? rdData : `RMAC_RESET_VAL;
            regRdValid <= rdPend_reg;
            ifBandwidthKhz <= bwKhz;
            ifFreqKhz <= (if_filter_bw_sel == RMAC_BW_300) ?
                         `RMAC_IF_KHZ_WIDE : `RMAC_IF_KHZ_NORMAL;
            txModulation  <= tx_modulation_sel;
            txModReserved <= tx_modulation_sel[2];
            rxDemodulator <= rx_demodulator_sel;
            rxDemodReserved <= (rx_demodulator_sel != RMAC_DEM_FSK) &&
                               !demodOok;
            freqTrackEnable    <= trackOn && !demodOok;
            freqTrackFrozen    <= frozen_reg;
            freqTrackPolarity  <= trkModeCfg[`RMAC_POL_BIT];
            freqTrackAlgorithm <= trkModeCfg[`RMAC_ALG_HI:`RMAC_ALG_LO];
            freqTrackPropGain  <= demodOok ? 16'h0000 : propPow;
            freqTrackIntGain   <= demodOok ? 16'h0000 : intPow;
            ookThreshPropGain  <= demodOok ? propPow : 16'h0000;
            ookThreshIntGain   <= demodOok ? intPow : 16'h0000;
        end
    end

    AST_IF_SHIFT:
    assert property (@(posedge clk) disable iff (rst)
        (if_filter_bw_sel == RMAC_BW_300) |=>
        (ifFreqKhz == `RMAC_IF_KHZ_WIDE))
    else $error("IF did not move to 300 kHz");

    AST_IF_NORMAL:
    assert property (@(posedge clk) disable iff (rst)
        (if_filter_bw_sel != RMAC_BW_300) |=>
        (ifFreqKhz == `RMAC_IF_KHZ_NORMAL))
    else $error("IF not at 200 kHz");

    AST_BW_MAP:
    assert property (@(posedge clk) disable iff (rst)
        (if_filter_bw_sel == RMAC_BW_150) |=> (ifBandwidthKhz == 10'd150))
    else $error("Bandwidth code 1 not 150 kHz");

    AST_MOD_RES:
    assert property (@(posedge clk) disable iff (rst)
        (tx_modulation_sel > 3'd3) |=> txModReserved)
    else $error("Reserved modulation not flagged");

    AST_DEM_RES:
    assert property (@(posedge clk) disable iff (rst)
        (rx_demodulator_sel == 3'd1) |=> rxDemodReserved)
    else $error("Reserved demodulation not flagged");

    AST_TRK_OFF:
    assert property (@(posedge clk) disable iff (rst)
        (freq_track_mode == RMAC_TRK_OFF) |=> !freqTrackEnable)
    else $error("Tracking active while disabled");

    AST_LOCK_PRE:
    assert property (@(posedge clk) disable iff (rst)
        (freq_track_mode == RMAC_TRK_LOCK && preambleDet && !rxFrameEnd &&
         preambleMatch != 4'h0) ##1 (freq_track_mode == RMAC_TRK_LOCK)
        |=> freqTrackFrozen)
    else $error("Lock mode did not freeze on preamble");

    AST_LOCK_ENTRY:
    assert property (@(posedge clk) disable iff (rst)
        (modeLock && !lockPrev_reg && !lockEvent) |=> !frozen_reg)
    else $error("Lock mode entered already frozen");

    AST_KP_POW:
    assert property (@(posedge clk) disable iff (rst)
        (!demodOok && freq_track_prop_gain == 4'h3) |=>
        (freqTrackPropGain == 16'h0008))
    else $error("Proportional gain not 2^3");

    AST_OOK_KP:
    assert property (@(posedge clk) disable iff (rst)
        demodOok |=> (freqTrackPropGain == 16'h0000 &&
                      ookThreshPropGain != 16'h0000))
    else $error("OOK gain not routed to threshold loop");

    AST_KI_POW:
    assert property (@(posedge clk) disable iff (rst)
        (demodOok && freq_track_int_gain == 4'h6) |=>
        (ookThreshIntGain == 16'h0040))
    else $error("Integral gain not 2^6");

    AST_READBACK:
    assert property (@(posedge clk) disable iff (rst)
        (regWr && hitMod) ##1 (regRd && hitMod && !regWr) |=>
        ##1 (regRdData == $past(regWrData, 3)))
    else $error("Readback differs from write");
endmodule
`default_nettype wire

// ---- verilog/rmac_consts.svh ----
// Register offsets, field positions and decode constants for the config bank
`ifndef RMAC_CONSTS_SVH
`define RMAC_CONSTS_SVH
`define RMAC_ADDR_MODBW      10'h115
`define RMAC_ADDR_TRKMODE    10'h116
`define RMAC_ADDR_TRKGAIN    10'h117
`define RMAC_RESET_VAL       8'h00
`define RMAC_BW_HI           7
`define RMAC_BW_LO           6
`define RMAC_MOD_HI          5
`define RMAC_MOD_LO          3
`define RMAC_DEMOD_HI        2
`define RMAC_DEMOD_LO        0
`define RMAC_TRK_HI          1
`define RMAC_TRK_LO          0
`define RMAC_POL_BIT         4
`define RMAC_ALG_HI          3
`define RMAC_ALG_LO          2
`define RMAC_KP_HI           7
`define RMAC_KP_LO           4
`define RMAC_KI_HI           3
`define RMAC_KI_LO           0
`define RMAC_IF_KHZ_NORMAL   10'd200
`define RMAC_IF_KHZ_WIDE     10'd300
`define RMAC_BW_KHZ_0        10'd100
`define RMAC_BW_KHZ_1        10'd150
`define RMAC_BW_KHZ_2        10'd200
`define RMAC_BW_KHZ_3        10'd300
`define RMAC_ONE_HOT_ONE     16'h0001
`define RMAC_PREAMBLE_OFF    4'h0
`endif

// ---- verilog/rmac_pkg.sv ----
// Types for the radio modem configuration bank
package rmac_pkg;
    typedef enum logic [1:0] {
        RMAC_BW_100 = 2'b00,
        RMAC_BW_150 = 2'b01,
        RMAC_BW_200 = 2'b10,
        RMAC_BW_300 = 2'b11
    } rmac_bw_t;
    typedef enum logic [2:0] {
        RMAC_MOD_FSK   = 3'b000,
        RMAC_MOD_GFSK  = 3'b001,
        RMAC_MOD_OOK   = 3'b010,
        RMAC_MOD_CW    = 3'b011
    } rmac_mod_t;
    typedef enum logic [2:0] {
        RMAC_DEM_FSK = 3'b000,
        RMAC_DEM_OOK = 3'b010
    } rmac_dem_t;
    typedef enum logic [1:0] {
        RMAC_TRK_FREE    = 2'b00,
        RMAC_TRK_OFF     = 2'b01,
        RMAC_TRK_HOLD    = 2'b10,
        RMAC_TRK_LOCK    = 2'b11
    } rmac_trk_t;
endpackage

// ---- verilog/rmac_reg_store.sv ----
// Three-entry 8-bit register store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rmac_consts.svh"
module rmac_reg_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Write port
    input  wire logic                     wrEn,
    input  wire logic [$clog2(DEPTH)-1:0] wrIdx,
    input  wire logic [WIDTH-1:0]         wrData,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] rdIdx,
    output var  logic [WIDTH-1:0]         rdData,
    // Full contents
    output var  logic [DEPTH*WIDTH-1:0]   allData
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_reg[gi] <= WIDTH'(`RMAC_RESET_VAL);
                end else if (wrEn && wrIdx == gi) begin
                    mem_reg[gi] <= wrData;
                end
            end
            assign allData[gi*WIDTH +: WIDTH] = mem_reg[gi];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            rdData <= WIDTH'(`RMAC_RESET_VAL);
        end else begin
            rdData <= mem_reg[rdIdx];
        end
    end
endmodule
`default_nettype wire
